// ===== pkg/vwp_pkg.sv
/*
 * Shared constants for the video memory host write port: register
 * selects, control fields, region codes, memory geometry, buffer entry.
 * Assumes a 32-bit host bus with word-indexed register selects.
 */
package vwp_pkg;
    localparam int REG_SEL_W = 2;
    localparam logic [1:0] REG_PORT_CONTROL = 2'h0;
    localparam logic [1:0] REG_VIDEO_MEMORY_POINTER = 2'h1;
    localparam logic [1:0] REG_WRITE_DATA_LOWER_HALF = 2'h2;
    localparam logic [1:0] REG_WRITE_DATA_UPPER_HALF = 2'h3;

    localparam int BUS_W = 32;
    localparam int CTRL_STEP_LSB = 0;
    localparam int CTRL_STEP_W = 16;
    localparam int CTRL_OPEN_WRITE_BIT = 30;
    localparam int CTRL_IRQ_ENABLE_BIT = 31;

    localparam logic [31:0] PORT_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] VIDEO_MEMORY_POINTER_RESET = 32'h0000_0000;
    localparam logic [31:0] UPPER_HALF_RESET = 32'h0000_0000;

    // Region is the top nibble of the virtual address
    localparam int REGION_LSB = 28;
    localparam int OFFSET_FULL_W = 28;
    localparam logic [3:0] REGION_TILE_BUF = 4'h0;
    localparam logic [3:0] REGION_TILE_GFX = 4'h1;
    localparam logic [3:0] REGION_SPRITE_GFX = 4'h2;
    localparam logic [3:0] REGION_PALETTE = 4'h3;
    localparam logic [3:0] REGION_OBJ_ATTR = 4'h4;

    localparam logic [27:0] TILE_BUF_DEPTH = 28'h00004B0;
    localparam logic [27:0] GFX_DEPTH = 28'h0004000;
    localparam logic [27:0] PALETTE_DEPTH = 28'h0000400;
    localparam logic [27:0] OBJ_ATTR_DEPTH = 28'h0000400;
    localparam int TILE_BUF_AW = 11;
    localparam int GFX_AW = 14;
    localparam int PALETTE_AW = 10;
    localparam int OBJ_ATTR_AW = 10;
    localparam int TILE_BUF_W = 16;
    localparam int GFX_W = 64;
    localparam int PALETTE_W = 24;
    localparam int OBJ_ATTR_W = 16;

    typedef enum logic [2:0]
    {
        TGT_TILE_BUF = 3'b000,
        TGT_TILE_GFX = 3'b001,
        TGT_SPRITE_GFX = 3'b010,
        TGT_PALETTE = 3'b011,
        TGT_OBJ_ATTR = 3'b100
    } vwp_target_e;

    localparam int OFFSET_W = 14;
    localparam int DATA_W = 64;
    localparam int ENT_DATA_LSB = 0;
    localparam int ENT_OFFSET_LSB = 64;
    localparam int ENT_TARGET_LSB = 78;
    localparam int ENTRY_W = 81;
endpackage : vwp_pkg

// ===== rtl/vwp_mem.sv
/*
 * Simple dual-port memory: one synchronous write port, one read port
 * with registered read data. Assumes a single clock.
 */
`timescale 1ns/10ps
module vwp_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // Clock
    input wire logic i_clk,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read port
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            store[i_waddr] <= i_wdata;
        end
    end

    // Out-of-range reads return unknown (X) data; caller keeps addresses in range
    always_ff @(posedge i_clk)
    begin
        o_rdata <= store[i_raddr];
    end
endmodule : vwp_mem

// ===== rtl/vwp_buf2.sv
/*
 * Two-entry buffer with valid/ready on both sides. Full and empty are
 * flops so the host-facing stall comes straight from a register.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
module vwp_buf2 #(
    parameter int WIDTH = 81
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    logic [WIDTH-1:0] slot_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic full_reg;
    logic empty_reg;
    logic push;
    logic pop;

    assign push = i_in_valid && !full_reg;
    assign pop = i_out_ready && !empty_reg;
    assign o_in_ready = !full_reg;
    assign o_out_valid = !empty_reg;
    assign o_out_data = slot_reg[rd_ptr_reg];

    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
        begin
            count_next = count_reg + 2'h1;
        end
        else if (pop && !push)
        begin
            count_next = count_reg - 2'h1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            slot_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_next;
            full_reg <= (count_next == 2'h2);
            empty_reg <= (count_next == 2'h0);
        end
    end
endmodule : vwp_buf2

// ===== rtl/vwp_host_port.sv
/*
 * Host write port into the five picture memories. Holds the four
 * write-only registers, decodes the virtual address, queues writes in a
 * two-entry buffer and drains them into the memories.
 * Assumes a synchronous host bus with chip select, write strobe and
 * waitrequest, a vertical-blank level from the video timing, and a
 * draw pipeline that may stall memory writes while it owns the ports.
 */
//
// Notes on behaviour
// - Tile buffer sits at 0x00000000, 1200 words of 16 bits.
// - Tile graphics sits at 0x10000000, 16384 words of 64 bits.
// - Sprite graphics sits at 0x20000000, 16384 words of 64 bits.
// - Palettes sit at 0x30000000, 1024 words of 24 bits.
// - Object attributes sit at 0x40000000, 1024 words of 16 bits.
// - Each memory is its own array, all seen as one address space.
// - Bus is 32 bits; 64-bit words come as lower and upper halves.
// - Control bits 15:0 give the pointer step; zero means no step.
// - Control bit 31 enables the vertical-blank interrupt.
// - Control bit 30 allows memory writes outside vertical blank.
// - Pointer register holds the virtual address that gets decoded.
// - Lower-half write fires a memory write using pointer and upper half.
// - After each fired write a nonzero step is added to the pointer.
// - Upper half only matters for the two 64-bit graphics memories.
// - Narrow memories keep only the low bits of the lower half.
// - Vertical-blank interrupt goes out on the bus interrupt line.
`timescale 1ns/10ps
module vwp_host_port (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Host register bus
    input wire logic i_chipselect,
    input wire logic i_write,
    input wire logic [vwp_pkg::REG_SEL_W-1:0] i_address,
    input wire logic [vwp_pkg::BUS_W-1:0] i_writedata,
    output logic o_waitrequest,
    output logic o_irq,
    // Video timing and draw pipeline
    input wire logic i_vblank,
    input wire logic i_mem_stall,
    // Draw pipeline read ports
    input wire logic [vwp_pkg::TILE_BUF_AW-1:0] i_tile_buf_raddr,
    output logic [vwp_pkg::TILE_BUF_W-1:0] o_tile_buf_rdata,
    input wire logic [vwp_pkg::GFX_AW-1:0] i_tile_gfx_raddr,
    output logic [vwp_pkg::GFX_W-1:0] o_tile_gfx_rdata,
    input wire logic [vwp_pkg::GFX_AW-1:0] i_sprite_gfx_raddr,
    output logic [vwp_pkg::GFX_W-1:0] o_sprite_gfx_rdata,
    input wire logic [vwp_pkg::PALETTE_AW-1:0] i_palette_raddr,
    output logic [vwp_pkg::PALETTE_W-1:0] o_palette_rdata,
    input wire logic [vwp_pkg::OBJ_ATTR_AW-1:0] i_obj_attr_raddr,
    output logic [vwp_pkg::OBJ_ATTR_W-1:0] o_obj_attr_rdata
);
    import vwp_pkg::*;

    logic [31:0] port_control_reg;
    logic [31:0] video_memory_pointer_reg;
    logic [31:0] upper_half_reg;
    logic irq_reg;

    logic buf_in_ready;
    logic buf_out_valid;
    logic [ENTRY_W-1:0] buf_out_data;
    logic drain;

    logic accept;
    logic lower_write;
    logic [CTRL_STEP_W-1:0] step;
    logic writes_allowed;
    logic mapped;
    vwp_target_e tgt;
    logic push;
    logic [DATA_W-1:0] push_data;
    logic [ENTRY_W-1:0] push_entry;

    vwp_target_e out_tgt;
    logic [OFFSET_W-1:0] out_offset;
    logic [DATA_W-1:0] out_data;

    // Region nibble to target; only five regions exist
    function automatic vwp_target_e region_target(input logic [3:0] region);
        vwp_target_e t;
        t = TGT_TILE_BUF;
        if (region == REGION_TILE_GFX)
        begin
            t = TGT_TILE_GFX;
        end
        else if (region == REGION_SPRITE_GFX)
        begin
            t = TGT_SPRITE_GFX;
        end
        else if (region == REGION_PALETTE)
        begin
            t = TGT_PALETTE;
        end
        else if (region == REGION_OBJ_ATTR)
        begin
            t = TGT_OBJ_ATTR;
        end
        return t;
    endfunction : region_target

    // True when the address lands inside one memory's span
    function automatic logic addr_mapped(input logic [31:0] addr);
        logic [3:0] region;
        logic [27:0] offset;
        logic ok;
        region = addr[31:REGION_LSB];
        offset = addr[OFFSET_FULL_W-1:0];
        ok = 1'b0;
        if (region == REGION_TILE_BUF)
        begin
            ok = offset < TILE_BUF_DEPTH;
        end
        else if (region == REGION_TILE_GFX || region == REGION_SPRITE_GFX)
        begin
            ok = offset < GFX_DEPTH;
        end
        else if (region == REGION_PALETTE)
        begin
            ok = offset < PALETTE_DEPTH;
        end
        else if (region == REGION_OBJ_ATTR)
        begin
            ok = offset < OBJ_ATTR_DEPTH;
        end
        return ok;
    endfunction : addr_mapped

    function automatic logic is_wide(input vwp_target_e t);
        return (t == TGT_TILE_GFX) || (t == TGT_SPRITE_GFX);
    endfunction : is_wide

    // Bus writes are held off while the buffer is full
    assign accept = i_chipselect && i_write && buf_in_ready;
    assign lower_write = accept && (i_address == REG_WRITE_DATA_LOWER_HALF);
    assign step = port_control_reg[CTRL_STEP_LSB +: CTRL_STEP_W];
    assign writes_allowed = port_control_reg[CTRL_OPEN_WRITE_BIT] || i_vblank;
    assign mapped = addr_mapped(video_memory_pointer_reg);
    assign tgt = region_target(video_memory_pointer_reg[31:REGION_LSB]);
    assign push = lower_write && mapped && writes_allowed;

    // Upper half joins only for 64-bit targets
    assign push_data = is_wide(tgt) ? {upper_half_reg, i_writedata}
                                    : {32'h0000_0000, i_writedata};
    assign push_entry = {tgt, video_memory_pointer_reg[OFFSET_W-1:0], push_data};

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            port_control_reg <= PORT_CONTROL_RESET;
        end
        else if (accept && i_address == REG_PORT_CONTROL)
        begin
            port_control_reg <= i_writedata;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            upper_half_reg <= UPPER_HALF_RESET;
        end
        else if (accept && i_address == REG_WRITE_DATA_UPPER_HALF)
        begin
            upper_half_reg <= i_writedata;
        end
    end

    // Pointer steps even for dropped writes, so bursts stay aligned
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            video_memory_pointer_reg <= VIDEO_MEMORY_POINTER_RESET;
        end
        else if (accept && i_address == REG_VIDEO_MEMORY_POINTER)
        begin
            video_memory_pointer_reg <= i_writedata;
        end
        else if (lower_write && step != 16'h0000)
        begin
            video_memory_pointer_reg <= video_memory_pointer_reg + {16'h0000, step};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= port_control_reg[CTRL_IRQ_ENABLE_BIT] && i_vblank;
        end
    end

    assign o_irq = irq_reg;

    vwp_buf2 #(
        .WIDTH(ENTRY_W)
    ) u_buf (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(push),
        .i_in_data(push_entry),
        .o_in_ready(buf_in_ready),
        .o_out_valid(buf_out_valid),
        .o_out_data(buf_out_data),
        .i_out_ready(!i_mem_stall)
    );

    assign o_waitrequest = !buf_in_ready;
    assign drain = buf_out_valid && !i_mem_stall;
    assign out_tgt = vwp_target_e'(buf_out_data[ENT_TARGET_LSB +: 3]);
    assign out_offset = buf_out_data[ENT_OFFSET_LSB +: OFFSET_W];
    assign out_data = buf_out_data[ENT_DATA_LSB +: DATA_W];

    // Separate arrays per memory, each at its own width
    vwp_mem #(
        .WIDTH(TILE_BUF_W),
        .DEPTH(1200),
        .AW(TILE_BUF_AW)
    ) u_tile_buf (
        .i_clk(i_clk),
        .i_we(drain && out_tgt == TGT_TILE_BUF),
        .i_waddr(out_offset[TILE_BUF_AW-1:0]),
        .i_wdata(out_data[TILE_BUF_W-1:0]),
        .i_raddr(i_tile_buf_raddr),
        .o_rdata(o_tile_buf_rdata)
    );

    vwp_mem #(
        .WIDTH(GFX_W),
        .DEPTH(16384),
        .AW(GFX_AW)
    ) u_tile_gfx (
        .i_clk(i_clk),
        .i_we(drain && out_tgt == TGT_TILE_GFX),
        .i_waddr(out_offset[GFX_AW-1:0]),
        .i_wdata(out_data),
        .i_raddr(i_tile_gfx_raddr),
        .o_rdata(o_tile_gfx_rdata)
    );

    vwp_mem #(
        .WIDTH(GFX_W),
        .DEPTH(16384),
        .AW(GFX_AW)
    ) u_sprite_gfx (
        .i_clk(i_clk),
        .i_we(drain && out_tgt == TGT_SPRITE_GFX),
        .i_waddr(out_offset[GFX_AW-1:0]),
        .i_wdata(out_data),
        .i_raddr(i_sprite_gfx_raddr),
        .o_rdata(o_sprite_gfx_rdata)
    );

    vwp_mem #(
        .WIDTH(PALETTE_W),
        .DEPTH(1024),
        .AW(PALETTE_AW)
    ) u_palette (
        .i_clk(i_clk),
        .i_we(drain && out_tgt == TGT_PALETTE),
        .i_waddr(out_offset[PALETTE_AW-1:0]),
        .i_wdata(out_data[PALETTE_W-1:0]),
        .i_raddr(i_palette_raddr),
        .o_rdata(o_palette_rdata)
    );

    vwp_mem #(
        .WIDTH(OBJ_ATTR_W),
        .DEPTH(1024),
        .AW(OBJ_ATTR_AW)
    ) u_obj_attr (
        .i_clk(i_clk),
        .i_we(drain && out_tgt == TGT_OBJ_ATTR),
        .i_waddr(out_offset[OBJ_ATTR_AW-1:0]),
        .i_wdata(out_data[OBJ_ATTR_W-1:0]),
        .i_raddr(i_obj_attr_raddr),
        .o_rdata(o_obj_attr_rdata)
    );

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    pointer_step_a: assert property (
        lower_write && step != 16'h0000 |=>
        video_memory_pointer_reg == $past(video_memory_pointer_reg) + {16'h0000, $past(step)})
        else $error("pointer did not advance by step");

    pointer_hold_a: assert property (
        lower_write && step == 16'h0000 |=> $stable(video_memory_pointer_reg))
        else $error("pointer moved with zero step");

    irq_gate_a: assert property (
        !port_control_reg[CTRL_IRQ_ENABLE_BIT] |=> !o_irq)
        else $error("interrupt raised while disabled");

    irq_follow_a: assert property (
        port_control_reg[CTRL_IRQ_ENABLE_BIT] && i_vblank |=> o_irq)
        else $error("interrupt missing during vertical blank");

    blocked_drop_a: assert property (
        lower_write && !i_vblank && !port_control_reg[CTRL_OPEN_WRITE_BIT] |-> !push)
        else $error("write queued outside vertical blank");

    unmapped_drop_a: assert property (
        lower_write && !mapped |-> !push)
        else $error("unmapped write queued");

    narrow_zero_a: assert property (
        push && !is_wide(tgt) |-> push_data[63:32] == 32'h0000_0000)
        else $error("upper half leaked into narrow write");

    wide_pair_a: assert property (
        push && is_wide(tgt) |-> push_data == {upper_half_reg, i_writedata})
        else $error("wide word not paired from halves");

    tile_range_a: assert property (
        drain && out_tgt == TGT_TILE_BUF |-> out_offset < 14'h04B0)
        else $error("tile buffer write beyond its span");

    stall_wait_a: assert property (
        buf_out_valid && i_mem_stall && push |=> o_waitrequest)
        else $error("buffer full without waitrequest");

    burst_c: cover property (lower_write && step != 16'h0000 ##[1:8] lower_write);
    blocked_c: cover property (lower_write && mapped && !writes_allowed);
    wide_c: cover property (drain && is_wide(out_tgt));
    full_c: cover property (o_waitrequest && i_chipselect && i_write);
endmodule : vwp_host_port

// ===== testbench/vwp_host_model.sv
/*
 * Host processor model for the video memory write port: issues register
 * writes and holds each one until waitrequest lets it through.
 * Assumes the bench calls write_reg and release_bus hierarchically.
 */
`timescale 1ns/10ps
module vwp_host_model (
    // Clock
    input wire logic i_clk,
    // Register bus toward the port
    output logic o_chipselect,
    output logic o_write,
    output logic [vwp_pkg::REG_SEL_W-1:0] o_address,
    output logic [vwp_pkg::BUS_W-1:0] o_writedata,
    input wire logic i_waitrequest
);
    import vwp_pkg::*;

    initial
    begin
        o_chipselect = 1'b0;
        o_write = 1'b0;
        o_address = 2'h0;
        o_writedata = 32'hA5A5_5A5A;
    end

    // One 32-bit word a request; wide words go as two halves
    task automatic write_reg(input logic [1:0] sel, input logic [31:0] data,
        output bit ok);
        int n = 0;
        @(negedge i_clk);
        o_chipselect = 1'b1;
        o_write = 1'b1;
        o_address = sel;
        o_writedata = data;
        // Waitrequest is a flop, so its value now is what the next edge sees
        while (i_waitrequest !== 1'b0 && n < 64)
        begin
            @(negedge i_clk);
            n++;
        end
        ok = (n < 64);
        @(posedge i_clk);
        // Drop the request so an idle edge never takes it twice
        release_bus();
    endtask : write_reg

    // Idle bus shows no stale value
    task automatic release_bus();
        @(negedge i_clk);
        o_chipselect = 1'b0;
        o_write = 1'b0;
        o_address = ~o_address;
        o_writedata = ~o_writedata;
    endtask : release_bus
endmodule : vwp_host_model

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for the video memory host write port.
 * Assumes the host model drives the register bus; the bench drives
 * vertical blank, drain stall and read ports at the falling edge.
 */
`timescale 1ns/10ps
module tb_top;
    import vwp_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cs, wr_en, waitreq, irq;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic vblank = 1'b1;
    logic stall = 1'b0;
    logic [13:0] raddr = 14'h0000;
    logic [15:0] rd_tile, rd_obj;
    logic [63:0] rd_tgfx, rd_sgfx;
    logic [23:0] rd_pal;
    int failures = 0;
    int total_checks = 0;

    always #2 clk = ~clk;

    vwp_host_model host (.i_clk(clk), .o_chipselect(cs), .o_write(wr_en),
        .o_address(addr), .o_writedata(wdata), .i_waitrequest(waitreq));

    vwp_host_port dut (.i_clk(clk), .i_reset(reset), .i_chipselect(cs),
        .i_write(wr_en), .i_address(addr), .i_writedata(wdata),
        .o_waitrequest(waitreq), .o_irq(irq), .i_vblank(vblank),
        .i_mem_stall(stall), .i_tile_buf_raddr(raddr[10:0]),
        .o_tile_buf_rdata(rd_tile), .i_tile_gfx_raddr(raddr),
        .o_tile_gfx_rdata(rd_tgfx), .i_sprite_gfx_raddr(raddr),
        .o_sprite_gfx_rdata(rd_sgfx), .i_palette_raddr(raddr[9:0]),
        .o_palette_rdata(rd_pal), .i_obj_attr_raddr(raddr[9:0]),
        .o_obj_attr_rdata(rd_obj));

    task automatic report_and_stop();
        $display("Checks made %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [1:0] sel, input logic [31:0] data);
        bit ok;
        host.write_reg(sel, data, ok);
        if (!ok)
        begin
            failures++;
            $display("ERROR bus write expected taken seen stuck");
            report_and_stop();
        end
    endtask : wr

    // Pointer first, upper half next, lower half last; step is left as set
    task automatic vm_write(input logic [31:0] ptr, input logic [31:0] hi, lo);
        wr(REG_VIDEO_MEMORY_POINTER, ptr);
        wr(REG_WRITE_DATA_UPPER_HALF, hi);
        wr(REG_WRITE_DATA_LOWER_HALF, lo);
    endtask : vm_write

    task automatic set_vblank(input logic v);
        @(negedge clk);
        vblank = v;
    endtask : set_vblank

    // Drain and read latency are fixed by the hand-over timing
    task automatic rd(input int tgt, input logic [13:0] a, output logic [63:0] d);
        host.release_bus();
        repeat (3) @(negedge clk);
        raddr = a;
        repeat (2) @(negedge clk);
        case (tgt)
            0: d = {48'h0, rd_tile};
            1: d = rd_tgfx;
            2: d = rd_sgfx;
            3: d = {40'h0, rd_pal};
            default: d = {48'h0, rd_obj};
        endcase
    endtask : rd

    task automatic check_regions();
        logic [3:0] reg_code [5] = '{REGION_TILE_BUF, REGION_TILE_GFX,
            REGION_SPRITE_GFX, REGION_PALETTE, REGION_OBJ_ATTR};
        logic [27:0] last [5] = '{TILE_BUF_DEPTH - 1, GFX_DEPTH - 1, GFX_DEPTH - 1,
            PALETTE_DEPTH - 1, OBJ_ATTR_DEPTH - 1};
        int w [5] = '{TILE_BUF_W, GFX_W, GFX_W, PALETTE_W, OBJ_ATTR_W};
        logic [63:0] d, exp;
        wr(REG_PORT_CONTROL, 32'h0000_0000);
        for (int i = 0; i < 5; i++)
        begin
            vm_write({reg_code[i], last[i]}, 32'hC0DE_0000 | i, 32'hFEED_BEE0 | i);
            exp = {32'hC0DE_0000 | i, 32'hFEED_BEE0 | i};
            if (w[i] < 64)
                exp = exp & ((64'h1 << w[i]) - 64'h1);
            rd(i, last[i][13:0], d);
            chk("region last word", d, exp);
        end
    endtask : check_regions

    // Out-of-range write must not alias; pointer still steps into palette 0
    task automatic check_unmapped();
        logic [63:0] d;
        wr(REG_PORT_CONTROL, 32'h0000_0001);
        vm_write(32'h2FFF_FFFF, 32'h1111_1111, 32'h0055_AA11);
        wr(REG_WRITE_DATA_LOWER_HALF, 32'hFFAB_CDEF);
        rd(2, 14'h3FFF, d);
        chk("sprite last word kept", d, 64'hC0DE_0002_FEED_BEE2);
        rd(3, 14'h0000, d);
        chk("palette after step", d, 64'h0000_0000_00AB_CDEF);
        vm_write(32'h5000_04AF, 32'h0, 32'h0000_9999);
        rd(0, 14'h04AF, d);
        chk("unmapped region dropped", d, 64'h0000_0000_0000_BEE0);
    endtask : check_unmapped

    task automatic check_gating();
        logic [63:0] d;
        wr(REG_PORT_CONTROL, 32'h0000_0004);
        vm_write(32'h4000_0010, 32'h0, 32'h0001_1111);
        set_vblank(1'b0);
        wr(REG_WRITE_DATA_LOWER_HALF, 32'h0000_2222);
        wr(REG_VIDEO_MEMORY_POINTER, 32'h4000_0010);
        wr(REG_WRITE_DATA_LOWER_HALF, 32'h0000_3333);
        set_vblank(1'b1);
        wr(REG_WRITE_DATA_LOWER_HALF, 32'h0000_4444);
        rd(4, 14'h0010, d);
        chk("blocked write dropped", d, 64'h1111);
        rd(4, 14'h0014, d);
        chk("pointer stepped when blocked", d, 64'h4444);
        wr(REG_PORT_CONTROL, 32'h4000_0000);
        set_vblank(1'b0);
        vm_write(32'h4000_0010, 32'h0, 32'h0000_5555);
        wr(REG_WRITE_DATA_LOWER_HALF, 32'h0000_6666);
        rd(4, 14'h0010, d);
        chk("open write, zero step", d, 64'h6666);
        rd(4, 14'h0014, d);
        chk("zero step kept pointer", d, 64'h4444);
        set_vblank(1'b1);
    endtask : check_gating

    task automatic check_burst();
        logic [63:0] d;
        wr(REG_PORT_CONTROL, 32'h0000_0003);
        wr(REG_VIDEO_MEMORY_POINTER, 32'h2000_0010);
        for (int k = 0; k < 3; k++)
        begin
            wr(REG_WRITE_DATA_UPPER_HALF, 32'hAB00_0000 | k);
            wr(REG_WRITE_DATA_LOWER_HALF, 32'h0000_CD00 | k);
        end
        for (int k = 0; k < 3; k++)
        begin
            rd(2, 14'h0010 + 14'(3 * k), d);
            chk("burst word", d, {32'hAB00_0000 | k, 32'h0000_CD00 | k});
        end
    endtask : check_burst

    task automatic check_stall();
        logic [63:0] d;
        wr(REG_PORT_CONTROL, 32'h0000_0001);
        wr(REG_VIDEO_MEMORY_POINTER, 32'h0000_0007);
        @(negedge clk);
        stall = 1'b1;
        wr(REG_WRITE_DATA_LOWER_HALF, 32'hDEAD_0A01);
        wr(REG_WRITE_DATA_LOWER_HALF, 32'hDEAD_0A02);
        @(negedge clk);
        chk("waitrequest when full", {63'h0, waitreq}, 64'h1);
        fork
            wr(REG_WRITE_DATA_LOWER_HALF, 32'hDEAD_0A03);
            begin
                repeat (3) @(negedge clk);
                chk("write held while full", {63'h0, waitreq}, 64'h1);
                stall = 1'b0;
            end
        join
        for (int k = 0; k < 3; k++)
        begin
            rd(0, 14'h0007 + 14'(k), d);
            chk("queued word", d, 64'h0A01 + k);
        end
    endtask : check_stall

    task automatic check_irq();
        wr(REG_PORT_CONTROL, 32'h8000_0000);
        set_vblank(1'b0);
        @(negedge clk);
        chk("irq idle", {63'h0, irq}, 64'h0);
        set_vblank(1'b1);
        @(negedge clk);
        chk("irq in vblank", {63'h0, irq}, 64'h1);
        set_vblank(1'b0);
        @(negedge clk);
        chk("irq after vblank", {63'h0, irq}, 64'h0);
        wr(REG_PORT_CONTROL, 32'h0000_0000);
        set_vblank(1'b1);
        repeat (2) @(negedge clk);
        chk("irq masked", {63'h0, irq}, 64'h0);
    endtask : check_irq

    initial
    begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk("waitrequest after reset", {63'h0, waitreq}, 64'h0);
        chk("irq after reset", {63'h0, irq}, 64'h0);
        check_regions();
        check_unmapped();
        check_gating();
        check_burst();
        check_stall();
        check_irq();
        report_and_stop();
    end
endmodule : tb_top
